// [rtl/cpm_pkg.sv]
package cpm_pkg;

  // Bus and vector widths.
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned NP = 8;
  localparam int unsigned NS = 9;

  // Register byte addresses.
  localparam logic [7:0] A_PLL = 8'h00;
  localparam logic [7:0] A_MSEL = 8'h04;
  localparam logic [7:0] A_CPUDIV = 8'h08;
  localparam logic [7:0] A_CLOCK_OUTPUT_FUNCTION = 8'h0C;
  localparam logic [7:0] A_GATE = 8'h10;
  localparam logic [7:0] A_PDIV0 = 8'h14;
  localparam logic [7:0] A_PDIV1 = 8'h18;
  localparam logic [7:0] A_PWR = 8'h1C;
  localparam logic [7:0] A_APD = 8'h20;
  localparam logic [7:0] A_OSC = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;

  // Field positions.
  localparam int unsigned PLL_ON_BIT = 0;
  localparam int unsigned PLL_DIV_LSB = 1;
  localparam int unsigned CO_DIV_LSB = 8;
  localparam int unsigned PWR_DEEP_BIT = 0;
  localparam int unsigned PWR_WDO_BIT = 1;
  localparam int unsigned PWR_BOD_BIT = 2;
  localparam int unsigned OSC_EN_BIT = 0;
  localparam int unsigned OSC_EXT_BIT = 1;
  localparam int unsigned ST_SEL_LSB = 4;
  localparam int unsigned ST_LOCK_BIT = 6;
  localparam int unsigned ST_STABLE_BIT = 7;

  // Synchroniser bit positions.
  localparam int unsigned S_PIN = 0;
  localparam int unsigned S_WDT = 1;
  localparam int unsigned S_USART = 2;
  localparam int unsigned S_USYNC = 3;
  localparam int unsigned S_SPI = 4;
  localparam int unsigned S_I2C = 5;
  localparam int unsigned S_I2CSL = 6;
  localparam int unsigned S_LOCK = 7;
  localparam int unsigned S_STABLE = 8;

  // Reset values and the PLL post-divider base.
  localparam logic [7:0] CPUDIV_RST = 8'h01;
  localparam logic [7:0] PDIV_RST = 8'h01;
  localparam logic [7:0] GATE_RST = 8'hFF;
  localparam logic [7:0] APD_RST = 8'hFF;
  localparam logic [7:0] ENTRY_CYCLES = 8'h04;
  localparam logic [7:0] PLL_DIV_BASE = 8'h02;

  // Clock sources for the main clock.
  typedef enum logic [1:0] {
    SRC_IRC = 2'h0,
    SRC_SYSTEM_CRYSTAL_OSCILLATOR = 2'h1,
    SRC_PLL = 2'h2,
    SRC_WDO = 2'h3
  } cpm_src_type;

  // Clock sources for the clock output function.
  typedef enum logic [1:0] {
    CO_IRC = 2'h0,
    CO_SYSTEM_CRYSTAL_OSCILLATOR = 2'h1,
    CO_WDO = 2'h2,
    CO_MAIN = 2'h3
  } cpm_co_type;

  // Power modes.
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_DENTER = 4'h4,
    ST_DEEP = 4'h8
  } cpm_state_type;

endpackage

// [rtl/cpm_tick_div.sv]
module cpm_tick_div (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Input rate and ratio; a ratio of zero stops the output.
  input wire logic in_tick,
  input wire logic [7:0] ratio,
  // One output pulse per ratio input pulses.
  output logic out_tick
);

  logic [7:0] cnt;
  logic [7:0] last;
  logic wrap;

  assign last = ratio - 8'h01;
  assign wrap = (cnt >= last);
  assign out_tick = in_tick && (ratio != 8'h00) && wrap;

  // Counts input pulses and restarts on the final one.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
    end else if (in_tick) begin
      cnt <= wrap ? 8'h00 : cnt + 8'h01;
    end
  end

endmodule

// [rtl/cpm_clock_power.sv]
// Operation
// - PLL post-divider divides by 2, 4, 8 or 16, so duty is even.
// - After reset the PLL is off and bypassed until software enables it.
// - Clock output drives RC, system or watchdog oscillator, or main clock.
// - At power-up the main clock runs from the internal RC oscillator.
// - Each peripheral has its own clock gate bit; gated means no clock.
// - CPU clock has a divider; selected peripherals have their own dividers.
// - Sleep stops the core clock; leaving Sleep just restarts it.
// - Sleep lasts until reset or interrupt; peripherals keep their clocks.
// - Deep-sleep stops peripheral clocks, all sources but RC, and watchdog unless kept on.
// - Deep-sleep powers down analog blocks and puts flash in standby.
// - Watchdog oscillator and brownout detector may stay on in Deep-sleep.
// - Deep-sleep wakes only on pin, watchdog, USART, SPI or I2C events.
// - Gating the GPIO clock keeps pin direction and output states.
module cpm_clock_power (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Oscillator rate pulses.
  input wire logic irc_tick,
  input wire logic system_crystal_oscillator_tick,
  input wire logic extclk_tick,
  input wire logic wdosc_tick,
  input wire logic pll_vco_tick,
  // Analog status pins.
  input wire logic pll_lock,
  input wire logic system_crystal_oscillator_stable,
  // Core handshake.
  input wire logic sleep_req,
  input wire logic core_irq,
  output logic core_clk_en,
  // Wake sources.
  input wire logic wake_pin,
  input wire logic wdt_irq,
  input wire logic usart_irq,
  input wire logic usart_sync_slave,
  input wire logic spi_irq,
  input wire logic i2c_irq,
  input wire logic i2c_slave,
  // Peripheral clocks and clock output function.
  output logic [7:0] periph_clk_en,
  output logic clock_output_function,
  // Oscillator and analog controls.
  output logic pll_power_down,
  output logic pll_bypass,
  output logic irc_osc_on,
  output logic irc_out_en,
  output logic system_crystal_oscillator_on,
  output logic wdosc_on,
  output logic brownout_detector_on,
  output logic [7:0] analog_power_down_config,
  output logic flash_standby,
  output logic [3:0] power_mode
);

  cpm_pkg::cpm_state_type state;
  cpm_pkg::cpm_state_type next_state;
  logic [1:0] msel;
  logic [1:0] msel_act;
  logic pll_on;
  logic [1:0] pll_div;
  logic [7:0] cpu_div;
  logic [1:0] co_sel;
  logic [7:0] co_div;
  logic [7:0] peripheral_clock_gate_register;
  logic [7:0] pdiv0;
  logic [7:0] pdiv1;
  logic deep_sel;
  logic keep_wdo;
  logic keep_bod;
  logic [7:0] apd;
  logic osc_en;
  logic ext_sel;
  logic [7:0] entry_cnt;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] raw_in;

  // Synchronise asynchronous wake and status inputs.
  assign raw_in = {system_crystal_oscillator_stable, pll_lock, i2c_slave, i2c_irq, spi_irq,
                   usart_sync_slave, usart_irq, wdt_irq, wake_pin};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  logic lock_s;
  logic stable_s;
  logic wake_q;
  logic is_deep;

  assign lock_s = sync2[cpm_pkg::S_LOCK];
  assign stable_s = sync2[cpm_pkg::S_STABLE];
  assign wake_q = sync2[cpm_pkg::S_PIN] || sync2[cpm_pkg::S_WDT] ||
                  (sync2[cpm_pkg::S_USART] && sync2[cpm_pkg::S_USYNC]) ||
                  sync2[cpm_pkg::S_SPI] ||
                  (sync2[cpm_pkg::S_I2C] && sync2[cpm_pkg::S_I2CSL]);
  assign is_deep = (state == cpm_pkg::ST_DEEP);

  // Source rate pulses after the oscillator enables.
  logic irc_eff;
  logic sys_eff;
  logic wdo_eff;
  logic pll_ref;
  logic pll_post;
  logic pll_out;
  logic [7:0] pll_ratio;

  // the RC output is blocked in Deep-sleep.
  assign irc_eff = irc_tick && irc_out_en;
  assign sys_eff = system_crystal_oscillator_on && (ext_sel ? extclk_tick : system_crystal_oscillator_tick);
  assign wdo_eff = wdosc_tick && wdosc_on;
  assign pll_ref = osc_en ? sys_eff : irc_eff;
  // ratio is 2 shifted by the two-bit field: 2, 4, 8 or 16.
  assign pll_ratio = cpm_pkg::PLL_DIV_BASE << pll_div;

  cpm_tick_div u_pll_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_tick(pll_vco_tick && pll_on && !is_deep),
    .ratio(pll_ratio),
    .out_tick(pll_post)
  );

  // bypass passes the reference while the PLL is off.
  assign pll_out = pll_on ? pll_post : pll_ref;

  // main clock select, taken over only on an active source tick.
  logic sel_tick;
  logic main_tick;
  logic [3:0] src_ticks;

  assign src_ticks = {wdo_eff, pll_out, sys_eff, irc_eff};
  assign sel_tick = src_ticks[msel_act];
  assign main_tick = sel_tick && !is_deep;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      msel_act <= cpm_pkg::SRC_IRC;
    end else if (sel_tick) begin
      msel_act <= msel;
    end
  end

  logic cpu_tick;
  logic p0_tick;
  logic p1_tick;
  logic [7:0] base_ticks;

  cpm_tick_div u_cpu_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_tick(main_tick),
    .ratio(cpu_div),
    .out_tick(cpu_tick)
  );

  cpm_tick_div u_p0_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_tick(main_tick),
    .ratio(pdiv0),
    .out_tick(p0_tick)
  );

  cpm_tick_div u_p1_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_tick(main_tick),
    .ratio(pdiv1),
    .out_tick(p1_tick)
  );

  // the core runs only in Run mode.
  assign core_clk_en = cpu_tick && (state == cpm_pkg::ST_RUN);
  assign base_ticks = {{5{main_tick}}, p1_tick, p0_tick, main_tick};
  // per-peripheral gates; gating stops pulses, no state is reset.
  assign periph_clk_en = base_ticks & peripheral_clock_gate_register;

  // clock output source selection and divider.
  logic co_src;
  logic co_tick;
  logic [3:0] co_ticks;
  logic co_level;

  assign co_ticks = {main_tick, wdo_eff, sys_eff, irc_eff};
  assign co_src = co_ticks[co_sel];

  cpm_tick_div u_co_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_tick(co_src),
    .ratio(co_div),
    .out_tick(co_tick)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      co_level <= 1'b0;
    end else if (co_tick) begin
      co_level <= !co_level;
    end
  end

  assign clock_output_function = co_level;

  // Power mode sequencer.
  always_comb begin
    next_state = state;
    case (state)
      cpm_pkg::ST_RUN: begin
        if (sleep_req) begin
          next_state = deep_sel ? cpm_pkg::ST_DENTER : cpm_pkg::ST_SLEEP;
        end
      end
      cpm_pkg::ST_SLEEP: begin
        if (core_irq) begin
          next_state = cpm_pkg::ST_RUN;
        end
      end
      // a wake during entry returns to Run.
      cpm_pkg::ST_DENTER: begin
        if (wake_q) begin
          next_state = cpm_pkg::ST_RUN;
        end else if (entry_cnt == 8'h00) begin
          next_state = cpm_pkg::ST_DEEP;
        end
      end
      cpm_pkg::ST_DEEP: begin
        if (wake_q) begin
          next_state = cpm_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = cpm_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cpm_pkg::ST_RUN;
      entry_cnt <= cpm_pkg::ENTRY_CYCLES;
    end else begin
      state <= next_state;
      if (state == cpm_pkg::ST_DENTER && entry_cnt != 8'h00) begin
        entry_cnt <= entry_cnt - 8'h01;
      end else if (state != cpm_pkg::ST_DENTER) begin
        entry_cnt <= cpm_pkg::ENTRY_CYCLES;
      end
    end
  end

  // oscillator controls; optional watchdog and brownout.
  assign irc_osc_on = 1'b1;
  assign irc_out_en = !is_deep;
  assign system_crystal_oscillator_on = osc_en && !is_deep;
  assign wdosc_on = !is_deep || keep_wdo;
  assign brownout_detector_on = !is_deep || keep_bod;
  // PLL off and bypassed unless software enables it.
  assign pll_power_down = !pll_on || is_deep;
  assign pll_bypass = !pll_on;
  // in Deep-sleep, analog blocks down and flash in standby.
  assign analog_power_down_config = is_deep ? 8'hFF : apd;
  assign flash_standby = is_deep;
  assign power_mode = state;

  // Register writes.
  logic wr_pll;
  logic wr_msel;
  logic wr_cpu;
  logic wr_co;
  logic wr_gate;
  logic wr_p0;
  logic wr_p1;
  logic wr_pwr;
  logic wr_apd;
  logic wr_osc;

  assign wr_pll = reg_wr && (reg_addr == cpm_pkg::A_PLL);
  assign wr_msel = reg_wr && (reg_addr == cpm_pkg::A_MSEL);
  assign wr_cpu = reg_wr && (reg_addr == cpm_pkg::A_CPUDIV);
  assign wr_co = reg_wr && (reg_addr == cpm_pkg::A_CLOCK_OUTPUT_FUNCTION);
  assign wr_gate = reg_wr && (reg_addr == cpm_pkg::A_GATE);
  assign wr_p0 = reg_wr && (reg_addr == cpm_pkg::A_PDIV0);
  assign wr_p1 = reg_wr && (reg_addr == cpm_pkg::A_PDIV1);
  assign wr_pwr = reg_wr && (reg_addr == cpm_pkg::A_PWR);
  assign wr_apd = reg_wr && (reg_addr == cpm_pkg::A_APD);
  assign wr_osc = reg_wr && (reg_addr == cpm_pkg::A_OSC);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_on <= 1'b0;
      pll_div <= 2'h0;
      msel <= cpm_pkg::SRC_IRC;
      cpu_div <= cpm_pkg::CPUDIV_RST;
      co_sel <= cpm_pkg::CO_IRC;
      co_div <= 8'h00;
      peripheral_clock_gate_register <= cpm_pkg::GATE_RST;
      pdiv0 <= cpm_pkg::PDIV_RST;
      pdiv1 <= cpm_pkg::PDIV_RST;
      deep_sel <= 1'b0;
      keep_wdo <= 1'b0;
      keep_bod <= 1'b0;
      apd <= cpm_pkg::APD_RST;
      osc_en <= 1'b0;
      ext_sel <= 1'b0;
    end else begin
      if (wr_pll) begin
        pll_on <= reg_wdata[cpm_pkg::PLL_ON_BIT];
        pll_div <= reg_wdata[cpm_pkg::PLL_DIV_LSB +: 2];
      end
      if (wr_msel) msel <= reg_wdata[1:0];
      if (wr_cpu) cpu_div <= reg_wdata[7:0];
      if (wr_co) begin
        co_sel <= reg_wdata[1:0];
        co_div <= reg_wdata[cpm_pkg::CO_DIV_LSB +: 8];
      end
      if (wr_gate) peripheral_clock_gate_register <= reg_wdata[7:0];
      if (wr_p0) pdiv0 <= reg_wdata[7:0];
      if (wr_p1) pdiv1 <= reg_wdata[7:0];
      if (wr_pwr) begin
        deep_sel <= reg_wdata[cpm_pkg::PWR_DEEP_BIT];
        keep_wdo <= reg_wdata[cpm_pkg::PWR_WDO_BIT];
        keep_bod <= reg_wdata[cpm_pkg::PWR_BOD_BIT];
      end
      if (wr_apd) apd <= reg_wdata[7:0];
      if (wr_osc) begin
        osc_en <= reg_wdata[cpm_pkg::OSC_EN_BIT];
        ext_sel <= reg_wdata[cpm_pkg::OSC_EXT_BIT];
      end
    end
  end

  // Register reads; data stands only in the cycle after the strobe.
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  // lock shows in status so software can wait before selecting.
  assign stat_word = {24'h000000, stable_s, lock_s, msel_act, state};

  always_comb begin
    case (reg_addr)
      cpm_pkg::A_PLL: rd_mux = {29'h00000000, pll_div, pll_on};
      cpm_pkg::A_MSEL: rd_mux = {30'h00000000, msel};
      cpm_pkg::A_CPUDIV: rd_mux = {24'h000000, cpu_div};
      cpm_pkg::A_CLOCK_OUTPUT_FUNCTION: rd_mux = {16'h0000, co_div, 6'h00, co_sel};
      cpm_pkg::A_GATE: rd_mux = {24'h000000, peripheral_clock_gate_register};
      cpm_pkg::A_PDIV0: rd_mux = {24'h000000, pdiv0};
      cpm_pkg::A_PDIV1: rd_mux = {24'h000000, pdiv1};
      cpm_pkg::A_PWR: rd_mux = {29'h00000000, keep_bod, keep_wdo, deep_sel};
      cpm_pkg::A_APD: rd_mux = {24'h000000, apd};
      cpm_pkg::A_OSC: rd_mux = {30'h00000000, ext_sel, osc_en};
      cpm_pkg::A_STAT: rd_mux = stat_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // Checks.
  chk_pll_even_div: assert property (
    @(posedge mclk) disable iff (!rst_n) pll_post |=> !pll_post)
    else $error("PLL post pulses too close.");

  chk_pll_stays_off: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!pll_on && !wr_pll) |=> (pll_bypass && pll_power_down))
    else $error("PLL left bypass without a write.");

  chk_co_toggle_src: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(co_level) |-> $past(co_src))
    else $error("Clock output toggled without source.");

  chk_gate_blocks: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (periph_clk_en & ~peripheral_clock_gate_register) == 8'h00)
    else $error("Gated peripheral got a clock.");

  chk_sleep_core_off: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state != cpm_pkg::ST_RUN) |-> !core_clk_en)
    else $error("Core clocked while asleep.");

  chk_sleep_irq_wake: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state == cpm_pkg::ST_SLEEP && core_irq) |=> (state == cpm_pkg::ST_RUN))
    else $error("Sleep did not end on interrupt.");

  chk_deep_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    is_deep |-> (periph_clk_en == 8'h00 && !irc_out_en && !system_crystal_oscillator_on))
    else $error("Clock active in Deep-sleep.");

  chk_deep_analog: assert property (
    @(posedge mclk) disable iff (!rst_n)
    is_deep |-> (flash_standby && analog_power_down_config == 8'hFF))
    else $error("Analog or flash not down in Deep-sleep.");

  chk_deep_keep_wdo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (is_deep && keep_wdo) |-> wdosc_on)
    else $error("Watchdog oscillator stopped.");

  chk_deep_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (is_deep && !wake_q) |=> is_deep)
    else $error("Deep-sleep left without wake.");

  chk_entry_abort: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (state == cpm_pkg::ST_DENTER && wake_q) |=> (state == cpm_pkg::ST_RUN))
    else $error("Wake lost during Deep-sleep entry.");

  chk_switch_on_tick: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(msel_act) |-> $past(sel_tick))
    else $error("Source switched mid-period.");

endmodule

// [sim/cpm_far_side.sv]
module cpm_far_side #(
  parameter int LOCK_CYC = 24,
  parameter int STAB_CYC = 16
) (
  // Clock, reset and oscillator controls from the block.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pll_power_down,
  input wire logic system_crystal_oscillator_on,
  input wire logic wdosc_on,
  // Rate pulses and analog status.
  output logic irc_tick,
  output logic system_crystal_oscillator_tick,
  output logic extclk_tick,
  output logic wdosc_tick,
  output logic pll_vco_tick,
  output logic pll_lock,
  output logic system_crystal_oscillator_stable
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph, lk, st;
  // Oscillators that are powered off give no pulses.
  assign irc_tick = (ph % 2) == 0;
  assign system_crystal_oscillator_tick = system_crystal_oscillator_on && ((ph % 3) == 0);
  assign extclk_tick = (ph % 4) == 0;
  assign wdosc_tick = wdosc_on && ((ph % 5) == 0);
  assign pll_vco_tick = !pll_power_down;
  assign pll_lock = lk == LOCK_CYC;
  assign system_crystal_oscillator_stable = st == STAB_CYC;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 0;
      lk <= 0;
      st <= 0;
    end else begin
      ph <= ph + 1;
      lk <= pll_power_down ? 0 : (lk < LOCK_CYC ? lk + 1 : lk);
      st <= system_crystal_oscillator_on ? (st < STAB_CYC ? st + 1 : st) : 0;
    end
  end
endmodule

// [sim/test_cpm_clock_power.sv]
module test_cpm_clock_power;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_req = 1'b0;
  logic core_irq = 1'b0;
  logic [6:0] wake = 7'h00;
  logic [31:0] reg_rdata, d;
  logic irc_tick, system_crystal_oscillator_tick, extclk_tick, wdosc_tick, pll_vco_tick;
  logic pll_lock, system_crystal_oscillator_stable, core_clk_en, clock_output_function;
  logic pll_power_down, pll_bypass, irc_osc_on, irc_out_en, system_crystal_oscillator_on;
  logic wdosc_on, brownout_detector_on, flash_standby;
  logic [7:0] periph_clk_en, analog_power_down_config, seen;
  logic [3:0] power_mode;
  logic [13:0] vec;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int ce, p1, co;
  logic [7:0] ra [12] = '{cpm_pkg::A_PLL, cpm_pkg::A_MSEL, cpm_pkg::A_CPUDIV,
    cpm_pkg::A_CLOCK_OUTPUT_FUNCTION, cpm_pkg::A_GATE, cpm_pkg::A_PDIV0, cpm_pkg::A_PDIV1,
    cpm_pkg::A_PWR, cpm_pkg::A_APD, cpm_pkg::A_OSC, cpm_pkg::A_STAT, 8'h2C};
  logic [31:0] re [12] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'hFF, 32'h1, 32'h1,
    32'h0, 32'hFF, 32'h0, 32'h1, 32'h0};
  logic [7:0] wa [7] = '{cpm_pkg::A_CPUDIV, cpm_pkg::A_GATE, cpm_pkg::A_PDIV0,
    cpm_pkg::A_CLOCK_OUTPUT_FUNCTION, cpm_pkg::A_APD, cpm_pkg::A_STAT, 8'h2C};
  logic [31:0] wv [7] = '{32'hFFFF_FF03, 32'h0000_015A, 32'h0000_0302,
    32'hFFFF_0403, 32'h0000_0100, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] we [7] = '{32'h3, 32'h5A, 32'h2, 32'h403, 32'h0, 32'h1, 32'h0};
  int co_want [4] = '{60, 40, 24, 60};
  logic [6:0] wk [5] = '{7'h01, 7'h02, 7'h0C, 7'h10, 7'h60};

  always #4 mclk = ~mclk;
  assign vec = {irc_out_en, irc_osc_on, system_crystal_oscillator_on, wdosc_on,
    brownout_detector_on, flash_standby, analog_power_down_config};

  cpm_clock_power cpm_clock_power_inst (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irc_tick(irc_tick), .system_crystal_oscillator_tick(system_crystal_oscillator_tick),
    .extclk_tick(extclk_tick), .wdosc_tick(wdosc_tick),
    .pll_vco_tick(pll_vco_tick), .pll_lock(pll_lock),
    .system_crystal_oscillator_stable(system_crystal_oscillator_stable), .sleep_req(sleep_req),
    .core_irq(core_irq), .core_clk_en(core_clk_en), .wake_pin(wake[0]),
    .wdt_irq(wake[1]), .usart_irq(wake[2]), .usart_sync_slave(wake[3]),
    .spi_irq(wake[4]), .i2c_irq(wake[5]), .i2c_slave(wake[6]),
    .periph_clk_en(periph_clk_en),
    .clock_output_function(clock_output_function),
    .pll_power_down(pll_power_down), .pll_bypass(pll_bypass),
    .irc_osc_on(irc_osc_on), .irc_out_en(irc_out_en),
    .system_crystal_oscillator_on(system_crystal_oscillator_on), .wdosc_on(wdosc_on),
    .brownout_detector_on(brownout_detector_on),
    .analog_power_down_config(analog_power_down_config),
    .flash_standby(flash_standby), .power_mode(power_mode));

  cpm_far_side cpm_far_side_inst (
    .mclk(mclk), .rst_n(rst_n), .pll_power_down(pll_power_down),
    .system_crystal_oscillator_on(system_crystal_oscillator_on), .wdosc_on(wdosc_on), .irc_tick(irc_tick),
    .system_crystal_oscillator_tick(system_crystal_oscillator_tick), .extclk_tick(extclk_tick),
    .wdosc_tick(wdosc_tick), .pll_vco_tick(pll_vco_tick),
    .pll_lock(pll_lock), .system_crystal_oscillator_stable(system_crystal_oscillator_stable));

  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Polls a status field until it shows the wanted value.
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    d = 32'h0;
    while ((d & m) !== v && i < 60) begin
      rd(cpm_pkg::A_STAT, d);
      i++;
    end
    chk(d & m, v);
  endtask

  task automatic wait_mode(input logic [3:0] m, input int lim);
    int i;
    i = 0;
    while (power_mode !== m && i < lim) begin
      @(negedge mclk);
      i++;
    end
    chk(32'(power_mode), 32'(m));
  endtask

  task automatic sleep_pulse;
    @(posedge mclk);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
  endtask

  // Counts core pulses, divided pulses and output toggles over n cycles.
  task automatic measure(input int n);
    logic last;
    @(negedge mclk);
    last = clock_output_function;
    ce = 0;
    p1 = 0;
    co = 0;
    seen = 8'h00;
    repeat (n) begin
      @(negedge mclk);
      if (core_clk_en === 1'b1) ce++;
      if (periph_clk_en[1] === 1'b1) p1++;
      if (clock_output_function !== last) co++;
      last = clock_output_function;
      seen = seen | periph_clk_en;
    end
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(32'({pll_power_down, pll_bypass}), 32'h3);
    for (int i = 0; i < 12; i++) begin
      rd(ra[i], d);
      chk(d, re[i]);
    end
    for (int i = 0; i < 7; i++) begin
      wr(wa[i], wv[i]);
      rd(wa[i], d);
      chk(d, we[i]);
    end
    repeat (8) @(posedge mclk);
    measure(120);
    chk(32'(ce), 32'h14);
    chk(32'(p1), 32'h1E);
    chk(32'(co), 32'h0F);
    chk(32'(seen), 32'h5A);
    wr(cpm_pkg::A_OSC, 32'h1);
    poll(32'h80, 32'h80);
    for (int s = 0; s < 4; s++) begin
      wr(cpm_pkg::A_CLOCK_OUTPUT_FUNCTION, 32'h100 | 32'(s));
      repeat (10) @(posedge mclk);
      measure(120);
      chk(32'(co), 32'(co_want[s]));
    end
    // External clock input replaces the system oscillator rate.
    wr(cpm_pkg::A_OSC, 32'h3);
    wr(cpm_pkg::A_CLOCK_OUTPUT_FUNCTION, 32'h101);
    repeat (10) @(posedge mclk);
    measure(120);
    chk(32'(co), 32'h1E);
    wr(cpm_pkg::A_PLL, 32'h3);
    @(negedge mclk);
    chk(32'(pll_power_down), 32'h0);
    poll(32'h40, 32'h40);
    wr(cpm_pkg::A_MSEL, 32'h2);
    poll(32'h30, 32'h20);
    repeat (8) @(posedge mclk);
    measure(120);
    chk(32'(ce), 32'h0A);
    chk(32'(p1), 32'h0F);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(32'({pll_power_down, pll_bypass}), 32'h3);
    chk(32'(power_mode), 32'h1);
    sleep_pulse();
    wait_mode(4'h2, 3);
    measure(40);
    chk(32'(ce), 32'h0);
    chk(32'(seen), 32'hFF);
    @(posedge mclk);
    wake <= 7'h01;
    repeat (8) @(posedge mclk);
    chk(32'(power_mode), 32'h2);
    core_irq <= 1'b1;
    wait_mode(4'h1, 4);
    @(posedge mclk);
    core_irq <= 1'b0;
    wake <= 7'h00;
    wr(cpm_pkg::A_PWR, 32'h1);
    repeat (4) @(posedge mclk);
    sleep_pulse();
    wait_mode(4'h4, 2);
    wait_mode(4'h8, 8);
    measure(40);
    chk(32'(ce), 32'h0);
    chk(32'(seen), 32'h0);
    chk(32'(vec), 32'h11FF);
    @(posedge mclk);
    core_irq <= 1'b1;
    wake <= 7'h24;
    repeat (8) @(posedge mclk);
    chk(32'(power_mode), 32'h8);
    core_irq <= 1'b0;
    wake <= 7'h00;
    wr(cpm_pkg::A_PWR, 32'h7);
    for (int i = 0; i < 5; i++) begin
      if (i > 0) begin
        repeat (4) @(posedge mclk);
        sleep_pulse();
        wait_mode(4'h8, 8);
      end
      if (i == 1) chk(32'(vec), 32'h17FF);
      @(posedge mclk);
      wake <= wk[i];
      wait_mode(4'h1, 5);
      @(posedge mclk);
      wake <= 7'h00;
    end
    wr(cpm_pkg::A_PWR, 32'h1);
    repeat (4) @(posedge mclk);
    wake <= 7'h01;
    sleep_pulse();
    ce = 0;
    repeat (12) begin
      @(negedge mclk);
      if (power_mode === 4'h8) ce++;
    end
    chk(32'(ce), 32'h0);
    chk(32'(power_mode), 32'h1);
    final_report();
  end
endmodule
